// file: src/smrc_pkg.sv
package smrc_pkg;

    // sleep mode encodings of the mode control field
    localparam logic [2:0] SMRC_MODE_IDLE = 3'h0;
    localparam logic [2:0] SMRC_MODE_ADCNR = 3'h1;
    localparam logic [2:0] SMRC_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SMRC_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SMRC_MODE_STBY = 3'h6;
    localparam logic [2:0] SMRC_MODE_XSTBY = 3'h7;
    localparam logic [2:0] SMRC_MODE_RST = 3'h0;

    // clock enable vector layout
    localparam int SMRC_CE_CPU = 0;
    localparam int SMRC_CE_IO = 1;
    localparam int SMRC_CE_ADC = 2;
    localparam int SMRC_CE_ASY = 3;
    localparam int SMRC_CE_OSC = 4;
    localparam int SMRC_CE_W = 5;
    localparam logic [4:0] SMRC_CE_ALL = 5'h1F;

    // port geometry and debug pins held pulled up on the control port
    localparam int SMRC_PORT_W = 8;
    localparam int SMRC_NPORT = 4;
    localparam int SMRC_PORT_ANA = 0;
    localparam int SMRC_PORT_DBG = 2;
    localparam logic [7:0] SMRC_DBG_PULL_MASK = 8'h2C;

    // timing at the 250 MHz clock
    localparam int SMRC_CLK_PS = 4000;
    localparam int SMRC_RST_MIN_NS = 1500;
    localparam int SMRC_RST_MIN_CYC = (SMRC_RST_MIN_NS * 1000 + SMRC_CLK_PS - 1) / SMRC_CLK_PS;
    localparam int SMRC_OSC_START_US = 16;
    localparam int SMRC_OSC_START_CYC = (SMRC_OSC_START_US * 1000000) / SMRC_CLK_PS;
    localparam int SMRC_FAST_START_CYC = 2;
    localparam int SMRC_CNT_W = 16;

    // sleep controller states, gray along active -> sleep -> wake
    typedef enum logic [1:0] {
        SMRC_ST_ACTIVE = 2'h0,
        SMRC_ST_SLEEP = 2'h1,
        SMRC_ST_WAKE = 2'h3
    } smrc_state_e;

endpackage

// file: src/smrc_port.sv
`timescale 1ns/10ps
// one 8-bit general purpose port: driver, direction and pull-ups
module smrc_port
    import smrc_pkg::*;
#(
    parameter int W = SMRC_PORT_W,
    parameter logic [7:0] KEEP_MASK = 8'h00
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic rst_any,
    input wire logic keep_en,
    input wire logic analog_sel,
    input wire logic pull_dis,
    input wire logic [W-1:0] out_val,
    input wire logic [W-1:0] dir_out,
    input wire logic [W-1:0] pull_sel,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pull_en
);
    logic [W-1:0] out_reg, out_next;
    logic [W-1:0] oe_reg, oe_next;
    logic [W-1:0] pu_reg, pu_next;

    // analog use takes the whole port away from the digital driver
    always_comb begin
        out_next = out_val;
        oe_next = analog_sel ? '0 : dir_out; // RULE11
        pu_next = (analog_sel || pull_dis) ? '0 : (pull_sel & ~dir_out); // RULE12
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            out_reg <= '0;
            oe_reg <= '0;
            pu_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            pu_reg <= pu_next;
        end
    end

    // reset gating is combinational so it holds with no clock running
    assign pin_o = out_reg;
    assign pin_oe = rst_any ? '0 : oe_reg; // RULE9
    assign pull_en = rst_any ? (keep_en ? W'(KEEP_MASK) : '0) : (pu_reg | (keep_en ? W'(KEEP_MASK) : '0)); // RULE10
endmodule

// file: src/smrc_rstflt.sv
`timescale 1ns/10ps
// synchronises the reset pin and qualifies lows by their length
module smrc_rstflt
    import smrc_pkg::*;
#(
    parameter int MIN_CYC = SMRC_RST_MIN_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pin_rst_n,
    output logic rst_req
);
    logic sync1_reg, sync2_reg;
    logic [SMRC_CNT_W-1:0] cnt_reg, cnt_next;
    logic req_reg, req_next;

    // long-enough low sets the request; it clears once the pin is high again
    always_comb begin
        cnt_next = cnt_reg;
        req_next = req_reg;
        if (sync2_reg) begin
            cnt_next = '0;
            req_next = 1'b0;
        end else if (cnt_reg >= SMRC_CNT_W'(MIN_CYC - 1)) begin
            req_next = 1'b1; // RULE8
        end else begin
            cnt_next = cnt_reg + SMRC_CNT_W'(1);
        end
    end

    // first sync stage feeds only the second
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            cnt_reg <= '0;
            req_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_rst_n;
            sync2_reg <= sync1_reg;
            cnt_reg <= cnt_next;
            req_reg <= req_next;
        end
    end

    assign rst_req = req_reg;
endmodule

// file: src/smrc_top.sv
`timescale 1ns/10ps
// Function
// (RULE1) six software-selectable sleep modes, each gating its own set of clocks
// (RULE2) idle halts the cpu; io, adc, timers and interrupts keep running
// (RULE3) power-down stops the oscillator; only external interrupt or reset wakes
// (RULE4) power-save keeps the asynchronous timer running as a time base
// (RULE5) adc noise reduction stops cpu and io except async timer and adc
// (RULE6) standby keeps the main oscillator running for fast wake-up
// (RULE7) extended standby keeps oscillator and asynchronous timer running
// (RULE8) reset pin low longer than minimum pulse resets, even with no clock; here the filter counts clock cycles, so reset needs the clock
// (RULE9) any active reset tri-states all general purpose port pins
// (RULE10) with debug port enabled its three input pull-ups stay on through reset
// (RULE11) first port is adc input, else an 8-bit bidirectional port
// (RULE12) each port pin has its own enable for an input pull-up
// (RULE13) mode field held, sleep command enters it, wake-up resumes execution
module smrc_top
    import smrc_pkg::*;
#(
    parameter int OSC_START_CYC = SMRC_OSC_START_CYC,
    parameter int RST_MIN_CYC = SMRC_RST_MIN_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic rst_pin_n,
    input wire logic mode_wr,
    input wire logic [2:0] mode_wdata,
    input wire logic sleep_en_wdata,
    input wire logic sleep_cmd,
    input wire logic ext_irq,
    input wire logic async_tmr_irq,
    input wire logic adc_irq,
    input wire logic periph_irq,
    input wire logic dbg_port_en,
    input wire logic adc_in_use,
    input wire logic pull_dis,
    input wire logic [31:0] port_out_val,
    input wire logic [31:0] port_dir_out,
    input wire logic [31:0] port_pull_sel,
    output logic [31:0] port_pin_o,
    output logic [31:0] port_pin_oe,
    output logic [31:0] port_pull_en,
    output logic adc_analog_sel,
    output logic cpu_clk_en,
    output logic io_clk_en,
    output logic adc_clk_en,
    output logic async_tmr_clk_en,
    output logic main_osc_en,
    output logic sleeping,
    output logic cpu_resume,
    output logic [2:0] mode_sel,
    output logic sys_rst_n
);
    smrc_state_e state_reg, state_next;
    logic [2:0] mode_reg, mode_next;
    logic sleep_en_reg, sleep_en_next;
    logic [2:0] act_mode_reg, act_mode_next;
    logic [SMRC_CNT_W-1:0] wait_reg, wait_next;
    logic [SMRC_CE_W-1:0] ce_reg, ce_next;
    logic resume_reg, resume_next;
    logic pin_rst_req;
    logic rst_any;
    logic wake_hit;
    logic mode_ok;

    // qualified reset request from the external pin
    smrc_rstflt #(
        .MIN_CYC(RST_MIN_CYC)
    ) u_rstflt (
        .clock(clock),
        .resetn(resetn),
        .pin_rst_n(rst_pin_n),
        .rst_req(pin_rst_req)
    );

    // raw pin low also counts here so ports float even with the clock stopped
    assign rst_any = !resetn || pin_rst_req || !rst_pin_n; // RULE9
    assign sys_rst_n = !(pin_rst_req || !resetn); // RULE8

    // clock enables that stay on while asleep in a given mode
    function automatic logic [SMRC_CE_W-1:0] smrc_ce_of(input logic [2:0] m);
        logic [SMRC_CE_W-1:0] ce;
        ce = '0;
        case (m)
            SMRC_MODE_IDLE: begin
                ce = SMRC_CE_ALL & ~(SMRC_CE_W'(1) << SMRC_CE_CPU); // RULE2
            end
            SMRC_MODE_ADCNR: begin
                ce[SMRC_CE_ADC] = 1'b1; // RULE5
                ce[SMRC_CE_ASY] = 1'b1;
                ce[SMRC_CE_OSC] = 1'b1;
            end
            SMRC_MODE_PDOWN: begin
                ce = '0; // RULE3
            end
            SMRC_MODE_PSAVE: begin
                ce[SMRC_CE_ASY] = 1'b1; // RULE4
            end
            SMRC_MODE_STBY: begin
                ce[SMRC_CE_OSC] = 1'b1; // RULE6
            end
            SMRC_MODE_XSTBY: begin
                ce[SMRC_CE_OSC] = 1'b1; // RULE7
                ce[SMRC_CE_ASY] = 1'b1;
            end
            default: begin
                ce = SMRC_CE_ALL;
            end
        endcase
        return ce;
    endfunction

    // which events may wake each mode; power-down and standby only on external
    function automatic logic smrc_wake_of(input logic [2:0] m, input logic e,
                                          input logic t, input logic a, input logic p);
        logic w;
        w = e;
        case (m)
            SMRC_MODE_IDLE: begin
                w = e || t || a || p;
            end
            SMRC_MODE_ADCNR: begin
                w = e || t || a;
            end
            SMRC_MODE_PSAVE, SMRC_MODE_XSTBY: begin
                w = e || t;
            end
            SMRC_MODE_PDOWN, SMRC_MODE_STBY: begin
                w = e; // RULE3
            end
            default: begin
                w = e;
            end
        endcase
        return w;
    endfunction

    assign mode_ok = (mode_reg != 3'h4) && (mode_reg != 3'h5); // RULE1
    assign wake_hit = smrc_wake_of(act_mode_reg, ext_irq, async_tmr_irq, adc_irq, periph_irq);

    // mode field and sleep enable, written by the core
    always_comb begin
        mode_next = mode_reg;
        sleep_en_next = sleep_en_reg;
        if (mode_wr) begin
            mode_next = mode_wdata; // RULE13
            sleep_en_next = sleep_en_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            mode_reg <= SMRC_MODE_RST;
            sleep_en_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            sleep_en_reg <= sleep_en_next;
        end
    end

    // sleep sequencer: enter on command, wait for wake, restart oscillator, resume
    always_comb begin
        state_next = state_reg;
        act_mode_next = act_mode_reg;
        wait_next = wait_reg;
        ce_next = ce_reg;
        resume_next = 1'b0;
        case (state_reg)
            SMRC_ST_ACTIVE: begin
                ce_next = SMRC_CE_ALL;
                if (sleep_cmd && sleep_en_reg && mode_ok) begin
                    act_mode_next = mode_reg; // RULE13
                    ce_next = smrc_ce_of(mode_reg); // RULE1
                    state_next = SMRC_ST_SLEEP;
                end
            end
            SMRC_ST_SLEEP: begin
                if (wake_hit) begin
                    // a stopped oscillator needs its start-up time; a running one does not
                    if (ce_reg[SMRC_CE_OSC]) begin
                        wait_next = SMRC_CNT_W'(SMRC_FAST_START_CYC - 1); // RULE6
                    end else begin
                        wait_next = SMRC_CNT_W'(OSC_START_CYC - 1);
                    end
                    ce_next[SMRC_CE_OSC] = 1'b1;
                    state_next = SMRC_ST_WAKE;
                end
            end
            SMRC_ST_WAKE: begin
                if (wait_reg == '0) begin
                    ce_next = SMRC_CE_ALL;
                    resume_next = 1'b1; // RULE13
                    state_next = SMRC_ST_ACTIVE;
                end else begin
                    wait_next = wait_reg - SMRC_CNT_W'(1);
                end
            end
            default: begin
                state_next = SMRC_ST_ACTIVE;
                ce_next = SMRC_CE_ALL;
            end
        endcase
        // a qualified pin reset aborts any sleep and restores all clocks
        if (pin_rst_req) begin
            state_next = SMRC_ST_ACTIVE; // RULE8
            ce_next = SMRC_CE_ALL;
            resume_next = 1'b0;
            wait_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= SMRC_ST_ACTIVE;
            act_mode_reg <= SMRC_MODE_RST;
            wait_reg <= '0;
            ce_reg <= SMRC_CE_ALL;
            resume_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            act_mode_reg <= act_mode_next;
            wait_reg <= wait_next;
            ce_reg <= ce_next;
            resume_reg <= resume_next;
        end
    end

    assign cpu_clk_en = ce_reg[SMRC_CE_CPU];
    assign io_clk_en = ce_reg[SMRC_CE_IO];
    assign adc_clk_en = ce_reg[SMRC_CE_ADC];
    assign async_tmr_clk_en = ce_reg[SMRC_CE_ASY];
    assign main_osc_en = ce_reg[SMRC_CE_OSC];
    assign sleeping = (state_reg != SMRC_ST_ACTIVE);
    assign cpu_resume = resume_reg;
    assign mode_sel = mode_reg;
    assign adc_analog_sel = adc_in_use; // RULE11

    // port 0 doubles as converter input; analog use takes its drivers and pulls away
    smrc_port #(
        .W(SMRC_PORT_W),
        .KEEP_MASK(8'h00)
    ) u_port0 (
        .clock(clock),
        .resetn(resetn),
        .rst_any(rst_any),
        .keep_en(1'b0),
        .analog_sel(adc_in_use), // RULE11
        .pull_dis(pull_dis),
        .out_val(port_out_val[SMRC_PORT_ANA*SMRC_PORT_W +: SMRC_PORT_W]),
        .dir_out(port_dir_out[SMRC_PORT_ANA*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_sel(port_pull_sel[SMRC_PORT_ANA*SMRC_PORT_W +: SMRC_PORT_W]), // RULE12
        .pin_o(port_pin_o[SMRC_PORT_ANA*SMRC_PORT_W +: SMRC_PORT_W]),
        .pin_oe(port_pin_oe[SMRC_PORT_ANA*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_en(port_pull_en[SMRC_PORT_ANA*SMRC_PORT_W +: SMRC_PORT_W])
    );

    // port 1 is plain digital: no analog use, nothing kept through reset
    smrc_port #(
        .W(SMRC_PORT_W),
        .KEEP_MASK(8'h00)
    ) u_port1 (
        .clock(clock),
        .resetn(resetn),
        .rst_any(rst_any),
        .keep_en(1'b0),
        .analog_sel(1'b0),
        .pull_dis(pull_dis),
        .out_val(port_out_val[1*SMRC_PORT_W +: SMRC_PORT_W]),
        .dir_out(port_dir_out[1*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_sel(port_pull_sel[1*SMRC_PORT_W +: SMRC_PORT_W]), // RULE12
        .pin_o(port_pin_o[1*SMRC_PORT_W +: SMRC_PORT_W]),
        .pin_oe(port_pin_oe[1*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_en(port_pull_en[1*SMRC_PORT_W +: SMRC_PORT_W])
    );

    // port 2 carries the debug inputs, whose pull-ups must survive any reset
    smrc_port #(
        .W(SMRC_PORT_W),
        .KEEP_MASK(SMRC_DBG_PULL_MASK)
    ) u_port2 (
        .clock(clock),
        .resetn(resetn),
        .rst_any(rst_any),
        .keep_en(dbg_port_en), // RULE10
        .analog_sel(1'b0),
        .pull_dis(pull_dis),
        .out_val(port_out_val[SMRC_PORT_DBG*SMRC_PORT_W +: SMRC_PORT_W]),
        .dir_out(port_dir_out[SMRC_PORT_DBG*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_sel(port_pull_sel[SMRC_PORT_DBG*SMRC_PORT_W +: SMRC_PORT_W]), // RULE12
        .pin_o(port_pin_o[SMRC_PORT_DBG*SMRC_PORT_W +: SMRC_PORT_W]),
        .pin_oe(port_pin_oe[SMRC_PORT_DBG*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_en(port_pull_en[SMRC_PORT_DBG*SMRC_PORT_W +: SMRC_PORT_W])
    );

    // port 3 is plain digital as well
    smrc_port #(
        .W(SMRC_PORT_W),
        .KEEP_MASK(8'h00)
    ) u_port3 (
        .clock(clock),
        .resetn(resetn),
        .rst_any(rst_any),
        .keep_en(1'b0),
        .analog_sel(1'b0),
        .pull_dis(pull_dis),
        .out_val(port_out_val[3*SMRC_PORT_W +: SMRC_PORT_W]),
        .dir_out(port_dir_out[3*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_sel(port_pull_sel[3*SMRC_PORT_W +: SMRC_PORT_W]), // RULE12
        .pin_o(port_pin_o[3*SMRC_PORT_W +: SMRC_PORT_W]),
        .pin_oe(port_pin_oe[3*SMRC_PORT_W +: SMRC_PORT_W]),
        .pull_en(port_pull_en[3*SMRC_PORT_W +: SMRC_PORT_W])
    );
endmodule

// file: tb/smrc_checker.sv
`timescale 1ns/10ps
// watches sleep gating, resume and reset pin behaviour at the top ports
module smrc_checker
    import smrc_pkg::*;
#(
    parameter int OSC_START_CYC = SMRC_OSC_START_CYC,
    parameter int RST_MIN_CYC = SMRC_RST_MIN_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic rst_pin_n,
    input wire logic dbg_port_en,
    input wire logic adc_in_use,
    input logic [31:0] port_pin_oe,
    input logic [31:0] port_pull_en,
    input logic adc_analog_sel,
    input logic cpu_clk_en,
    input logic io_clk_en,
    input logic adc_clk_en,
    input logic async_tmr_clk_en,
    input logic main_osc_en,
    input logic sleeping,
    input logic cpu_resume,
    input logic [2:0] mode_sel
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // enables gathered in package bit order, cpu at bit 0
    logic [4:0] ce;
    assign ce = {main_osc_en, async_tmr_clk_en, adc_clk_en, io_clk_en, cpu_clk_en};

    // entry into sleep: one cycle awake, then asleep
    sequence entry_s;
        !sleeping ##1 sleeping;
    endsequence

    // resume pulse lasts one cycle with every clock back on
    sequence resume_s;
        cpu_resume && !sleeping && ce == SMRC_CE_ALL ##1 !cpu_resume;
    endsequence

    cpu_halt_a: assert property (entry_s |-> !cpu_clk_en)
        else $error("cpu clock still on after sleep entry");
    idle_gate_a: assert property (entry_s |-> mode_sel != SMRC_MODE_IDLE || ce == 5'h1E)
        else $error("idle gating wrong");
    pdown_gate_a: assert property (entry_s |-> mode_sel != SMRC_MODE_PDOWN || ce == 5'h00)
        else $error("power-down gating wrong");
    psave_gate_a: assert property (entry_s |-> mode_sel != SMRC_MODE_PSAVE || ce == 5'h08)
        else $error("power-save gating wrong");
    adcnr_gate_a: assert property (entry_s |-> mode_sel != SMRC_MODE_ADCNR || ce == 5'h1C)
        else $error("adc noise reduction gating wrong");
    stby_gate_a: assert property (entry_s |-> mode_sel != SMRC_MODE_STBY || ce == 5'h10)
        else $error("standby gating wrong");
    xstby_gate_a: assert property (entry_s |-> mode_sel != SMRC_MODE_XSTBY || ce == 5'h18)
        else $error("extended standby gating wrong");
    resume_pulse_a: assert property (cpu_resume |-> resume_s)
        else $error("resume pulse malformed");
    pin_tristate_a: assert property (!rst_pin_n |-> port_pin_oe == 32'h0000_0000)
        else $error("port driven during pin reset");
    debug_pull_a: assert property (!rst_pin_n && dbg_port_en |->
        (port_pull_en[23:16] & SMRC_DBG_PULL_MASK) == SMRC_DBG_PULL_MASK)
        else $error("debug pull-ups dropped during reset");
    analog_sel_a: assert property (adc_analog_sel == adc_in_use)
        else $error("analog select does not follow converter use");
endmodule

bind smrc_top smrc_checker #(
    .OSC_START_CYC(OSC_START_CYC),
    .RST_MIN_CYC(RST_MIN_CYC)
) i_smrc_checker (
    .clock(clock), .resetn(resetn), .rst_pin_n(rst_pin_n), .dbg_port_en(dbg_port_en),
    .adc_in_use(adc_in_use), .port_pin_oe(port_pin_oe), .port_pull_en(port_pull_en),
    .adc_analog_sel(adc_analog_sel), .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en),
    .adc_clk_en(adc_clk_en), .async_tmr_clk_en(async_tmr_clk_en),
    .main_osc_en(main_osc_en), .sleeping(sleeping), .cpu_resume(cpu_resume),
    .mode_sel(mode_sel)
);

// file: tb/tb_smrc_top.sv
`timescale 1ns/10ps
module tb_smrc_top
    import smrc_pkg::*;
;
    localparam int OSC = 5;
    localparam int RMIN = 4;
    typedef struct {logic [2:0] m; logic [4:0] ce; logic [3:0] bad; logic [3:0] wk; int n;} smrc_row_s;
    // mode, enables asleep, an irq that must not wake it, one that must, wake wait
    smrc_row_s rows [6] = '{
        '{SMRC_MODE_IDLE, 5'h1E, 4'h0, 4'h8, SMRC_FAST_START_CYC},
        '{SMRC_MODE_ADCNR, 5'h1C, 4'h8, 4'h4, SMRC_FAST_START_CYC},
        '{SMRC_MODE_PDOWN, 5'h00, 4'h2, 4'h1, OSC},
        '{SMRC_MODE_PSAVE, 5'h08, 4'h4, 4'h2, OSC},
        '{SMRC_MODE_STBY, 5'h10, 4'h2, 4'h1, SMRC_FAST_START_CYC},
        '{SMRC_MODE_XSTBY, 5'h18, 4'h4, 4'h2, SMRC_FAST_START_CYC}};
    logic clock = 1'b0, resetn = 1'b0, rst_pin_n = 1'b1, mode_wr = 1'b0, sleep_cmd = 1'b0;
    logic sleep_en_wdata = 1'b0, dbg_port_en = 1'b1, adc_in_use = 1'b0, pull_dis = 1'b0;
    logic [2:0] mode_wdata = 3'h0;
    logic [3:0] irq_v = 4'h0;
    logic [31:0] out_val = 32'hA5A5_5A5A, dir = 32'h0F0F_F0F0, psel = 32'hFFFF_FFFF;
    logic [31:0] pin_o, pin_oe, pull_en;
    logic ana, cpu_en, io_en, adc_en, asy_en, osc_en, sleeping, cpu_resume, sys_rst_n;
    logic [2:0] mode_sel;
    wire logic [4:0] ce = {osc_en, asy_en, adc_en, io_en, cpu_en};
    int bad_count = 0, total_checks = 0, cnt;

    smrc_top #(.OSC_START_CYC(OSC), .RST_MIN_CYC(RMIN)) i_smrc_top (
        .clock(clock), .resetn(resetn), .rst_pin_n(rst_pin_n), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .sleep_en_wdata(sleep_en_wdata), .sleep_cmd(sleep_cmd),
        .ext_irq(irq_v[0]), .async_tmr_irq(irq_v[1]), .adc_irq(irq_v[2]),
        .periph_irq(irq_v[3]), .dbg_port_en(dbg_port_en), .adc_in_use(adc_in_use),
        .pull_dis(pull_dis), .port_out_val(out_val), .port_dir_out(dir),
        .port_pull_sel(psel), .port_pin_o(pin_o), .port_pin_oe(pin_oe),
        .port_pull_en(pull_en), .adc_analog_sel(ana), .cpu_clk_en(cpu_en),
        .io_clk_en(io_en), .adc_clk_en(adc_en), .async_tmr_clk_en(asy_en),
        .main_osc_en(osc_en), .sleeping(sleeping), .cpu_resume(cpu_resume),
        .mode_sel(mode_sel), .sys_rst_n(sys_rst_n));

    // 250 MHz clock
    initial begin
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // mode write then sleep command on the following cycle
    task automatic sleep_in(input logic [2:0] m, input logic en);
        @(posedge clock);
        mode_wr <= 1'b1;
        mode_wdata <= m;
        sleep_en_wdata <= en;
        @(posedge clock);
        mode_wr <= 1'b0;
        sleep_cmd <= 1'b1;
        @(posedge clock);
        sleep_cmd <= 1'b0;
        #1;
    endtask

    // generous bound; the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (9) @(posedge clock);
        #1;
        check(pin_oe, 32'h0000_0000);
        check(pin_o, 32'h0000_0000);
        check(pull_en, 32'h002C_0000);
        @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        #1;
        check({sleeping, mode_sel, ce}, {1'b0, 3'h0, SMRC_CE_ALL});
        check(pin_o, out_val);
        check(pin_oe, dir);
        check(pull_en, (psel & ~dir) | 32'h002C_0000);
        foreach (rows[i]) begin
            sleep_in(rows[i].m, 1'b1);
            check({sleeping, mode_sel, ce}, {1'b1, rows[i].m, rows[i].ce});
            @(posedge clock);
            irq_v <= rows[i].bad;
            repeat (3) @(posedge clock);
            irq_v <= rows[i].wk;
            #1;
            check({sleeping, ce}, {1'b1, rows[i].ce});
            @(posedge clock);
            irq_v <= 4'h0;
            cnt = 0;
            do begin
                @(posedge clock);
                #1;
                cnt++;
            end while (!cpu_resume && cnt < 20);
            check(cnt, rows[i].n);
            check({sleeping, ce}, {1'b0, SMRC_CE_ALL});
            @(posedge clock);
            #1;
            check(cpu_resume, 1'b0);
        end
        // disabled sleep and the two reserved codes are ignored
        sleep_in(SMRC_MODE_IDLE, 1'b0);
        check(sleeping, 1'b0);
        for (int r = 4; r < 6; r++) begin
            sleep_in(r[2:0], 1'b1);
            check(sleeping, 1'b0);
        end
        // converter use, then global pull-up disable
        @(posedge clock);
        adc_in_use <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(ana, 1'b1);
        check(pin_oe, dir & 32'hFFFF_FF00);
        check(pull_en, (psel & ~dir & 32'hFFFF_FF00) | 32'h002C_0000);
        @(posedge clock);
        pull_dis <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(pull_en, 32'h002C_0000);
        // debug port off: nothing keeps its pull-ups on
        @(posedge clock);
        dbg_port_en <= 1'b0;
        #1;
        check(pull_en, 32'h0000_0000);
        @(posedge clock);
        dbg_port_en <= 1'b1;
        // short pin pulse tri-states at once but must not reset
        @(posedge clock);
        rst_pin_n <= 1'b0;
        #1;
        check(pin_oe, 32'h0000_0000);
        check(pull_en, 32'h002C_0000);
        @(posedge clock);
        rst_pin_n <= 1'b1;
        repeat (6) begin
            @(posedge clock);
            #1;
            check(sys_rst_n, 1'b1);
        end
        // long pin reset aborts power-save but keeps the mode field
        sleep_in(SMRC_MODE_PSAVE, 1'b1);
        @(posedge clock);
        rst_pin_n <= 1'b0;
        repeat (RMIN + 4) @(posedge clock);
        #1;
        check({sys_rst_n, sleeping, cpu_resume, mode_sel, ce},
            {3'b000, SMRC_MODE_PSAVE, SMRC_CE_ALL});
        @(posedge clock);
        rst_pin_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check(sys_rst_n, 1'b1);
        close_out();
    end
endmodule
